// ---- hw/wpz_defs.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the waveform monitor.
// Assumes: Register port carries a 7-bit offset and 24-bit data.
// Notes:   Definitions only; included by wpz_monitor.sv and the bench, not by wpz_pkg.sv.
`ifndef WPZ_DEFS_SVH
`define WPZ_DEFS_SVH

// Register offsets.
`define WPZ_OFS_MEASUREMENT_MODE_REG        7'h14
`define WPZ_OFS_WAVEFORM_MODE_REG      7'h15
`define WPZ_OFS_LINE_CYCLE_MODE_REG     7'h17
`define WPZ_OFS_ZERO_CROSS_TIMEOUT_RELOAD       7'h1b
`define WPZ_OFS_OCLEVEL      7'h12
`define WPZ_OFS_CURRENT_PEAK_REG        7'h10
`define WPZ_OFS_VOLTAGE_PEAK_REG        7'h11
`define WPZ_OFS_WAVEFORM_OUTPUT_REG        7'h0e
`define WPZ_OFS_MASK         7'h18
`define WPZ_OFS_STATUS       7'h19
`define WPZ_OFS_STATUS_CLEAR_ON_READ      7'h1a

// Reset values.
`define WPZ_RST_ZERO_CROSS_TIMEOUT_RELOAD       16'hffff
`define WPZ_RST_OCLEVEL      8'hff
`define WPZ_RST_MEASUREMENT_MODE_REG        8'h1c
`define WPZ_RST_WAVEFORM_MODE_REG      8'h00
`define WPZ_RST_LINE_CYCLE_MODE_REG     8'h38
`define WPZ_RST_MASK         24'h000000

// Field positions in the mode registers.
`define WPZ_MM_PEAK_PHASE_SELECT_LSB   2
`define WPZ_MM_OCSEL_LSB     5
`define WPZ_WM_WAVEFORM_PHASE_SELECT_LSB     0
`define WPZ_WM_WAVEFORM_SOURCE_SELECT_LSB    2
`define WPZ_WM_RATE_LSB      5
`define WPZ_LC_ZERO_CROSS_SOURCE_SELECT_LSB     3

// Waveform source codes.
`define WPZ_WAVEFORM_SOURCE_SELECT_CURRENT   3'h0
`define WPZ_WAVEFORM_SOURCE_SELECT_VOLTAGE   3'h1

// Status and mask bit positions.
`define WPZ_ST_ZXTO_LSB      6
`define WPZ_ST_ZX_LSB        9
`define WPZ_ST_PKI           15
`define WPZ_ST_WAVEFORM_SAMPLE_MASK          16

// Magnitude field positions.
`define WPZ_I_MAG_LSB        14
`define WPZ_V_MAG_LSB        6

// Timing: the timeout counters step once per this many master clock periods.
`define WPZ_ZXTO_PERIODS     384
`define WPZ_ZXTO_CYCLES      (`WPZ_ZXTO_PERIODS)
// Half line cycles per peak window.
`define WPZ_PEAK_HALF_CYCLES 8'h08
// Low-pass shift: alpha of 1/16 at 26 kSPS puts the pole near 260 Hz.
`define WPZ_LPF_SHIFT        4

`endif

// ---- hw/wpz_pkg.sv ----
// Purpose: Types shared by the waveform monitor.
// Assumes: Nothing beyond the defs header.
// Notes:   Constants live in wpz_defs.svh.
package wpz_pkg;
    // State of the byte serializer that drains the sample buffer.
    typedef enum logic {
        WPZ_SER_IDLE,
        WPZ_SER_SEND
    } wpz_ser_e;

    // A 24-bit waveform word.
    typedef logic [23:0] wpz_word_t;
endpackage

// ---- hw/wpz_monitor.sv ----
// Purpose: Per-phase peak, overcurrent, waveform sampling and zero-cross supervision.
// Assumes: ADC samples arrive with adc_strobe at 26 kSPS, synchronous to clk.
// Notes:   Summary of operation follows.
`include "wpz_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module wpz_monitor (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        adc_strobe,
    input  wire logic [23:0] ia_sample,
    input  wire logic [23:0] ib_sample,
    input  wire logic [23:0] ic_sample,
    input  wire logic [15:0] va_sample,
    input  wire logic [15:0] vb_sample,
    input  wire logic [15:0] vc_sample,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [23:0] reg_wdata,
    output logic      [23:0] reg_rdata,
    output logic             irq_n,
    output logic      [7:0]  byte_data,
    output logic             byte_valid,
    input  wire logic        byte_ready,
    output logic      [47:0] v_mult_out,
    output logic      [47:0] v_rms_out,
    output logic             line_cycle_tick,
    output logic             period_zx_tick
);

    // Absolute value of a signed 24-bit word; the most negative code saturates.
    function automatic logic [23:0] abs24(input logic [23:0] v);
        logic [23:0] n;
        n = (~v) + 24'h000001;
        if (!v[23]) begin
            abs24 = v;
        end else if (n[23]) begin
            abs24 = 24'h7fffff;
        end else begin
            abs24 = n;
        end
    endfunction

    // Unsigned maximum of two bytes.
    function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
        max8 = (a > b) ? a : b;
    endfunction

    logic [23:0] i_s        [3];      // Current samples per phase.
    logic [15:0] v_s        [3];      // Raw voltage samples per phase.
    logic [15:0] lpf_r      [3];      // Filtered voltage per phase.
    logic [15:0] lpf_nxt    [3];      // Next filtered voltage.
    logic [7:0]  i_mag      [3];      // Current magnitude field.
    logic [7:0]  v_mag      [3];      // Filtered voltage magnitude field.
    logic [15:0] tout_r     [3];      // Hidden timeout counters.
    logic [2:0]  zx_pos;              // Rising crossings this cycle.
    logic [2:0]  zx_neg;              // Falling crossings this cycle.
    logic [7:0]  measurement_mode_reg_r;             // Measurement mode.
    logic [7:0]  waveform_mode_reg_r;           // Waveform mode.
    logic [7:0]  lcyc_r;              // Line-cycle mode.
    logic [15:0] zero_cross_timeout_reload_r;            // Timeout reload value.
    logic [7:0]  oclevel_r;           // Overcurrent level.
    logic [23:0] mask_r;              // Interrupt mask.
    logic [23:0] status_r;            // Sticky event flags.
    logic [23:0] set_v;               // Flags raised this cycle.
    logic [7:0]  current_peak_reg_r;             // Latched current peak.
    logic [7:0]  voltage_peak_reg_r;             // Latched voltage peak.
    logic [7:0]  trk_i_r;             // Running current peak.
    logic [7:0]  trk_v_r;             // Running voltage peak.
    logic [7:0]  hc_cnt_r;            // Half cycles in current window.
    logic        half_tick;           // A selected channel crossed zero.
    logic        win_end;             // Last half cycle of the window.
    logic [8:0]  pre_cnt_r;           // Divider for the timeout step.
    logic        to_tick;             // One timeout step.
    logic        oc_hit;              // A selected phase above level.
    logic [2:0]  dec_cnt_r;           // Rate decimation counter.
    logic        wf_take;             // A waveform sample is due.
    logic        wf_push;             // Sample enters the buffer.
    logic [23:0] wf_word;             // Sample chosen for output.
    logic [23:0] waveform_output_reg_r;             // Last sample offered to the host.
    logic [23:0] buf_mem    [2];      // Two-entry sample buffer.
    logic        buf_wp_r;            // Buffer write pointer.
    logic        buf_rp_r;            // Buffer read pointer.
    logic [1:0]  buf_cnt_r;           // Buffer fill level.
    logic        buf_in_ready;        // Room for a sample.
    logic        buf_out_valid;       // A sample waits.
    logic        buf_pop;             // Serializer takes a sample.
    wpz_pkg::wpz_ser_e ser_r;         // Serializer state.
    logic [23:0] ser_sh_r;            // Serializer shift register.
    logic [1:0]  ser_idx_r;           // Byte index within the word.
    logic        rd_clear;            // Clear-on-read access this cycle.

    assign i_s[0] = ia_sample;
    assign i_s[1] = ib_sample;
    assign i_s[2] = ic_sample;
    assign v_s[0] = va_sample;
    assign v_s[1] = vb_sample;
    assign v_s[2] = vc_sample;

    // Filter, magnitudes and crossing detection per phase.
    always_comb begin
        logic [16:0] diff;
        logic [23:0] ai;
        logic [23:0] av;
        diff = 17'h00000;
        ai   = 24'h000000;
        av   = 24'h000000;
        for (int p = 0; p < 3; p++) begin
            diff = {v_s[p][15], v_s[p]} - {lpf_r[p][15], lpf_r[p]};
            // Single-pole recursion: y += (x - y) / 16.
            lpf_nxt[p] = lpf_r[p] + 16'(signed'(diff) >>> `WPZ_LPF_SHIFT);
            // A function result cannot be sliced directly, so it passes through a local.
            ai       = abs24(i_s[p]);
            i_mag[p] = ai[`WPZ_I_MAG_LSB +: 8];
            av       = abs24({{8{lpf_r[p][15]}}, lpf_r[p]});
            v_mag[p] = av[`WPZ_V_MAG_LSB +: 8];
            // Crossings come from the filtered signal, never the raw one.
            zx_pos[p] = adc_strobe & lpf_r[p][15] & ~lpf_nxt[p][15];
            zx_neg[p] = adc_strobe & ~lpf_r[p][15] & lpf_nxt[p][15];
        end
    end

    // Filter state; the raw and filtered words are also offered outward.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int p = 0; p < 3; p++) begin
                lpf_r[p] <= 16'h0000;
            end
            v_mult_out <= 48'h000000000000;
            v_rms_out  <= 48'h000000000000;
        end else if (adc_strobe) begin
            for (int p = 0; p < 3; p++) begin
                lpf_r[p] <= lpf_nxt[p];
            end
            // Multipliers see the unfiltered word; rms sees the filtered one.
            v_mult_out <= {vc_sample, vb_sample, va_sample};
            v_rms_out  <= {lpf_nxt[2], lpf_nxt[1], lpf_nxt[0]};
        end
    end

    // Half-cycle count from the channels chosen for line-cycle timing.
    assign half_tick = |((zx_pos | zx_neg) & lcyc_r[`WPZ_LC_ZERO_CROSS_SOURCE_SELECT_LSB +: 3]);
    assign win_end   = half_tick && (hc_cnt_r == `WPZ_PEAK_HALF_CYCLES - 8'h01);

    // Line-cycle tick follows every selected crossing; the period tick only rising crossings of the phase in measurement mode bits 1:0.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hc_cnt_r        <= 8'h00;
            line_cycle_tick <= 1'b0;
            period_zx_tick  <= 1'b0;
        end else begin
            line_cycle_tick <= half_tick;
            period_zx_tick  <= |(zx_pos & (3'h1 << measurement_mode_reg_r[1:0]));
            if (win_end) begin
                hc_cnt_r <= 8'h00;
            end else if (half_tick) begin
                hc_cnt_r <= hc_cnt_r + 8'h01;
            end
        end
    end

    // Peak tracking; current and voltage both take the maximum over the same selected phases.
    always_ff @(posedge clk) begin
        logic [7:0] ci;
        logic [7:0] cv;
        ci = trk_i_r;
        cv = trk_v_r;
        for (int p = 0; p < 3; p++) begin
            if (adc_strobe && measurement_mode_reg_r[`WPZ_MM_PEAK_PHASE_SELECT_LSB + p]) begin
                ci = max8(ci, i_mag[p]);
                cv = max8(cv, v_mag[p]);
            end
        end
        if (!reset_n) begin
            trk_i_r <= 8'h00;
            trk_v_r <= 8'h00;
            current_peak_reg_r <= 8'h00;
            voltage_peak_reg_r <= 8'h00;
        end else if (win_end) begin
            // Latch the finished window and start the next from zero.
            current_peak_reg_r <= trk_i_r;
            voltage_peak_reg_r <= trk_v_r;
            trk_i_r <= 8'h00;
            trk_v_r <= 8'h00;
        end else begin
            trk_i_r <= ci;
            trk_v_r <= cv;
        end
    end

    // Overcurrent: any phase in the overcurrent selection above the level.
    always_comb begin
        oc_hit = 1'b0;
        for (int p = 0; p < 3; p++) begin
            if (measurement_mode_reg_r[`WPZ_MM_OCSEL_LSB + p] && (i_mag[p] > oclevel_r)) begin
                oc_hit = adc_strobe;
            end
        end
    end

    // Prescaler shared by the three timeout counters.
    assign to_tick = (pre_cnt_r == 9'(`WPZ_ZXTO_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pre_cnt_r <= 9'h000;
        end else if (to_tick) begin
            pre_cnt_r <= 9'h000;
        end else begin
            pre_cnt_r <= pre_cnt_r + 9'h001;
        end
    end

    // Timeout counters: reload on a rising crossing, otherwise step down and stop at zero.
    always_ff @(posedge clk) begin
        for (int p = 0; p < 3; p++) begin
            if (!reset_n) begin
                tout_r[p] <= `WPZ_RST_ZERO_CROSS_TIMEOUT_RELOAD;
            end else if (zx_pos[p]) begin
                tout_r[p] <= zero_cross_timeout_reload_r;
            end else if (to_tick && tout_r[p] != 16'h0000) begin
                tout_r[p] <= tout_r[p] - 16'h0001;
            end
        end
    end

    // Rate decimation: every 1st, 2nd, 4th or 8th ADC strobe is kept.
    assign wf_take = adc_strobe && ((dec_cnt_r & ((3'h1 << waveform_mode_reg_r[6:5]) - 3'h1)) == 3'h0);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dec_cnt_r <= 3'h0;
        end else if (adc_strobe) begin
            dec_cnt_r <= dec_cnt_r + 3'h1;
        end
    end

    // Source and phase selection for the waveform word.
    always_comb begin
        logic [1:0] ph;
        ph = waveform_mode_reg_r[`WPZ_WM_WAVEFORM_PHASE_SELECT_LSB +: 2];
        if (ph == 2'h3) begin
            ph = 2'h0;
        end
        if (waveform_mode_reg_r[`WPZ_WM_WAVEFORM_SOURCE_SELECT_LSB +: 3] == `WPZ_WAVEFORM_SOURCE_SELECT_VOLTAGE) begin
            // Filtered voltage, sign-extended to the 24-bit register.
            wf_word = {{8{lpf_nxt[ph][15]}}, lpf_nxt[ph]};
        end else begin
            wf_word = i_s[ph];
        end
    end

    // A sample only counts as available once the buffer accepted it.
    assign wf_push = wf_take && buf_in_ready &&
        ((waveform_mode_reg_r[`WPZ_WM_WAVEFORM_SOURCE_SELECT_LSB +: 3] == `WPZ_WAVEFORM_SOURCE_SELECT_VOLTAGE) ||
         (waveform_mode_reg_r[`WPZ_WM_WAVEFORM_SOURCE_SELECT_LSB +: 3] == `WPZ_WAVEFORM_SOURCE_SELECT_CURRENT));

    // Two-entry buffer; when full the ADC cannot wait, so that sample is skipped.
    assign buf_in_ready  = (buf_cnt_r != 2'h2);
    assign buf_out_valid = (buf_cnt_r != 2'h0);
    assign buf_pop       = buf_out_valid && (ser_r == wpz_pkg::WPZ_SER_IDLE);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            buf_wp_r  <= 1'b0;
            buf_rp_r  <= 1'b0;
            buf_cnt_r <= 2'h0;
            waveform_output_reg_r   <= 24'h000000;
        end else begin
            if (wf_push) begin
                buf_mem[buf_wp_r] <= wf_word;
                buf_wp_r          <= ~buf_wp_r;
                waveform_output_reg_r           <= wf_word;
            end
            if (buf_pop) begin
                buf_rp_r <= ~buf_rp_r;
            end
            buf_cnt_r <= buf_cnt_r + {1'b0, wf_push} - {1'b0, buf_pop};
        end
    end

    // Serializer: three bytes per word, most significant first.
    assign byte_valid = (ser_r == wpz_pkg::WPZ_SER_SEND);
    assign byte_data  = ser_sh_r[23:16];

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ser_r     <= wpz_pkg::WPZ_SER_IDLE;
            ser_sh_r  <= 24'h000000;
            ser_idx_r <= 2'h0;
        end else begin
            unique case (ser_r)
                wpz_pkg::WPZ_SER_IDLE: begin
                    if (buf_pop) begin
                        ser_sh_r  <= buf_mem[buf_rp_r];
                        ser_idx_r <= 2'h0;
                        ser_r     <= wpz_pkg::WPZ_SER_SEND;
                    end
                end
                wpz_pkg::WPZ_SER_SEND: begin
                    if (byte_ready) begin
                        ser_sh_r  <= {ser_sh_r[15:0], 8'h00};
                        ser_idx_r <= ser_idx_r + 2'h1;
                        if (ser_idx_r == 2'h2) begin
                            ser_r <= wpz_pkg::WPZ_SER_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Events of this cycle, by status position.
    always_comb begin
        set_v = 24'h000000;
        for (int p = 0; p < 3; p++) begin
            set_v[`WPZ_ST_ZX_LSB + p]   = zx_pos[p];
            set_v[`WPZ_ST_ZXTO_LSB + p] = to_tick && !zx_pos[p] &&
                                          (tout_r[p] == 16'h0001);
        end
        set_v[`WPZ_ST_PKI]  = oc_hit;
        set_v[`WPZ_ST_WAVEFORM_SAMPLE_MASK] = wf_push;
    end

    assign rd_clear = reg_rd && (reg_addr == `WPZ_OFS_STATUS_CLEAR_ON_READ);

    // Sticky flags; a new event wins over the clearing read in the same cycle.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status_r <= 24'h000000;
        end else if (rd_clear) begin
            status_r <= set_v;
        end else begin
            status_r <= status_r | set_v;
        end
    end

    // Interrupt follows any masked flag and holds until the clearing read.
    assign irq_n = ~|(status_r & mask_r);

    // Register writes.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            measurement_mode_reg_r   <= `WPZ_RST_MEASUREMENT_MODE_REG;
            waveform_mode_reg_r <= `WPZ_RST_WAVEFORM_MODE_REG;
            lcyc_r    <= `WPZ_RST_LINE_CYCLE_MODE_REG;
            zero_cross_timeout_reload_r  <= `WPZ_RST_ZERO_CROSS_TIMEOUT_RELOAD;
            oclevel_r <= `WPZ_RST_OCLEVEL;
            mask_r    <= `WPZ_RST_MASK;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `WPZ_OFS_MEASUREMENT_MODE_REG:    measurement_mode_reg_r   <= reg_wdata[7:0];
                `WPZ_OFS_WAVEFORM_MODE_REG:  waveform_mode_reg_r <= reg_wdata[7:0];
                `WPZ_OFS_LINE_CYCLE_MODE_REG: lcyc_r    <= reg_wdata[7:0];
                `WPZ_OFS_ZERO_CROSS_TIMEOUT_RELOAD:   zero_cross_timeout_reload_r  <= reg_wdata[15:0];
                `WPZ_OFS_OCLEVEL:  oclevel_r <= reg_wdata[7:0];
                `WPZ_OFS_MASK:     mask_r    <= reg_wdata;
                default: begin
                    // Writes to read-only or unmapped offsets are ignored.
                end
            endcase
        end
    end

    // Register reads, answered one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= 24'h000000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `WPZ_OFS_MEASUREMENT_MODE_REG:    reg_rdata <= {16'h0000, measurement_mode_reg_r};
                `WPZ_OFS_WAVEFORM_MODE_REG:  reg_rdata <= {16'h0000, waveform_mode_reg_r};
                `WPZ_OFS_LINE_CYCLE_MODE_REG: reg_rdata <= {16'h0000, lcyc_r};
                `WPZ_OFS_ZERO_CROSS_TIMEOUT_RELOAD:   reg_rdata <= {8'h00, zero_cross_timeout_reload_r};
                `WPZ_OFS_OCLEVEL:  reg_rdata <= {16'h0000, oclevel_r};
                `WPZ_OFS_MASK:     reg_rdata <= mask_r;
                `WPZ_OFS_CURRENT_PEAK_REG:    reg_rdata <= {16'h0000, current_peak_reg_r};
                `WPZ_OFS_VOLTAGE_PEAK_REG:    reg_rdata <= {16'h0000, voltage_peak_reg_r};
                `WPZ_OFS_WAVEFORM_OUTPUT_REG:    reg_rdata <= waveform_output_reg_r;
                `WPZ_OFS_STATUS,
                `WPZ_OFS_STATUS_CLEAR_ON_READ:  reg_rdata <= status_r;
                default:           reg_rdata <= 24'h000000;
            endcase
        end
    end

    // Checks beside the logic.
    peak_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
        win_end |=> (current_peak_reg_r == $past(trk_i_r)) && (trk_i_r == 8'h00))
        else $error("peak not latched at window end");
    zx_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
        zx_pos[0] |=> status_r[`WPZ_ST_ZX_LSB]) else $error("zero-cross flag missed");
    zx_reload_a: assert property (@(posedge clk) disable iff (!reset_n)
        zx_pos[1] |=> (tout_r[1] == $past(zero_cross_timeout_reload_r))) else $error("timeout not reloaded");
    tout_step_a: assert property (@(posedge clk) disable iff (!reset_n)
        (to_tick && !zx_pos[0] && tout_r[0] != 16'h0000)
        |=> (tout_r[0] == $past(tout_r[0]) - 16'h0001)) else $error("timeout step wrong");
    tout_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
        (to_tick && !zx_pos[2] && tout_r[2] == 16'h0001)
        |=> status_r[`WPZ_ST_ZXTO_LSB + 2] && tout_r[2] == 16'h0000)
        else $error("timeout flag missed");
    oc_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
        oc_hit |=> status_r[`WPZ_ST_PKI] && !(mask_r[`WPZ_ST_PKI] && irq_n))
        else $error("overcurrent flag or interrupt missed");
    irq_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rd_clear && set_v == 24'h000000) |=> irq_n && status_r == 24'h000000)
        else $error("interrupt not released by clearing read");
    wf_sample_a: assert property (@(posedge clk) disable iff (!reset_n)
        wf_push |=> status_r[`WPZ_ST_WAVEFORM_SAMPLE_MASK] && waveform_output_reg_r == $past(wf_word))
        else $error("waveform sample not posted");
    ser_bytes_a: assert property (@(posedge clk) disable iff (!reset_n)
        buf_pop |=> byte_valid && byte_data == $past(buf_mem[buf_rp_r][23:16]))
        else $error("first byte not most significant");
    buf_full_a: assert property (@(posedge clk) disable iff (!reset_n)
        (buf_cnt_r == 2'h2) |-> !wf_push) else $error("push into full buffer");

endmodule

`default_nettype wire

// ---- test/wpz_host_sink.sv ----
// Purpose: Host-side byte sink standing at the far end of the waveform stream.
// Assumes: A byte is taken on an edge where valid and ready are both high.
// Notes:   Stall holds ready low so the two-entry buffer must hold its words.
`timescale 1ns/1ps
`default_nettype none
module wpz_host_sink (
    input  wire logic       clk,
    input  wire logic [7:0] byte_data,
    input  wire logic       byte_valid,
    input  wire logic       stall,
    output logic            byte_ready
);
    logic [7:0] q[$]; // Bytes received, oldest first.
    // Ready falls while stalled, like a busy host that cannot service the port.
    assign byte_ready = !stall;
    // Only a handshaken byte is kept, so a repeated offer is never counted twice.
    always @(posedge clk) begin
        if (byte_valid && byte_ready) q.push_back(byte_data);
    end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: Self-checking bench for the waveform monitor.
// Assumes: 40 MHz clock, synchronous active-low reset held 20 cycles.
// Notes:   The bench tracks the voltage filter as y += (x-y)>>>4 per strobe.
`timescale 1ns/1ps
`default_nettype none
`include "wpz_defs.svh"
module tb_top;
    logic        clk = 0, reset_n = 0, adc_strobe = 0, reg_wr = 0, reg_rd = 0, stall = 0;
    logic [23:0] ia = 24'h2851ec, reg_wdata = 0, reg_rdata, d;
    logic [15:0] va = 0;
    logic [6:0]  reg_addr = 0;
    logic [7:0]  byte_data;
    logic        irq_n, byte_valid, byte_ready, lc_tick, pz_tick;
    logic [47:0] v_mult, v_rms;
    int          err_total = 0, num_checks = 0, vy = 0; // vy mirrors the filter.
    int          lc_cnt = 0, pz_cnt = 0; // Crossing pulses seen on the tick outputs.
    always @(posedge clk) begin
        if (lc_tick === 1'b1) lc_cnt++;
        if (pz_tick === 1'b1) pz_cnt++;
    end
    always #12.5 clk = ~clk;
    wpz_monitor wpz_monitor_inst (.clk(clk), .reset_n(reset_n), .adc_strobe(adc_strobe),
        .ia_sample(ia), .ib_sample(24'h0), .ic_sample(24'h0), .va_sample(va),
        .vb_sample(16'h0), .vc_sample(16'h0), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_n(irq_n),
        .byte_data(byte_data), .byte_valid(byte_valid), .byte_ready(byte_ready),
        .v_mult_out(v_mult), .v_rms_out(v_rms), .line_cycle_tick(lc_tick),
        .period_zx_tick(pz_tick));
    wpz_host_sink wpz_host_sink_inst (.clk(clk), .byte_data(byte_data),
        .byte_valid(byte_valid), .stall(stall), .byte_ready(byte_ready));
    // Compares with case equality so an unknown never passes.
    task chk(input logic [23:0] s, input logic [23:0] e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [6:0] a, input logic [23:0] v);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
        @(posedge clk);
        reg_wr <= 0;
    endtask
    // Read data is registered, so it is taken once the following edge has landed.
    task rd(input logic [6:0] a);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 0;
        #1 d = reg_rdata;
    endtask
    // Spaced strobes give the serializer time to drain one word each.
    task strb(input logic [15:0] v);
        @(posedge clk);
        {adc_strobe, va} <= {1'b1, v};
        @(posedge clk);
        adc_strobe <= 0;
        vy = vy + ((int'($signed(v)) - vy) >>> 4);
        repeat (9) @(posedge clk);
    endtask
    task half(input logic [15:0] v);
        repeat (40) strb(v);
    endtask
    task t_over;
        wr(`WPZ_OFS_MEASUREMENT_MODE_REG, 24'h00003c);
        wr(`WPZ_OFS_OCLEVEL, 24'h0000a1);
        wr(`WPZ_OFS_MASK, 24'h008000);
        strb(16'h0000);
        rd(`WPZ_OFS_STATUS);
        chk(d[15], 1'b0);
        wr(`WPZ_OFS_OCLEVEL, 24'h0000a0);
        strb(16'h0000);
        chk(irq_n, 1'b0);
        rd(`WPZ_OFS_STATUS_CLEAR_ON_READ);
        chk(d[15], 1'b1);
        chk(irq_n, 1'b1);
        wr(`WPZ_OFS_OCLEVEL, 24'h0000ff);
        $display("overcurrent done");
    endtask
    // Ten half cycles: only rising crossings may flag, and the peak window must close.
    task t_zero;
        wr(`WPZ_OFS_MASK, 24'h000200);
        for (int h = 0; h < 10; h++) begin
            half(h[0] ? 16'h2000 : 16'he000);
            chk(irq_n, !h[0]);
            rd(`WPZ_OFS_STATUS_CLEAR_ON_READ);
            chk(d[9], h[0]);
        end
        rd(`WPZ_OFS_CURRENT_PEAK_REG);
        chk(d, 24'h0000a1);
        chk(24'(lc_cnt), 24'd10);
        chk(24'(pz_cnt), 24'd5);
        $display("zero cross done");
    endtask
    // A reload of 2 must expire after two prescaler steps of 384 clocks.
    task t_tout;
        rd(`WPZ_OFS_ZERO_CROSS_TIMEOUT_RELOAD);
        chk(d, 24'h00ffff);
        wr(`WPZ_OFS_ZERO_CROSS_TIMEOUT_RELOAD, 24'h000002);
        half(16'he000);
        rd(`WPZ_OFS_STATUS_CLEAR_ON_READ);
        for (int i = 0; i < 40 && d[9] !== 1'b1; i++) begin
            strb(16'h2000);
            rd(`WPZ_OFS_STATUS);
        end
        rd(`WPZ_OFS_STATUS_CLEAR_ON_READ);
        repeat (300) @(posedge clk);
        rd(`WPZ_OFS_STATUS);
        chk(d[6], 1'b0);
        repeat (600) @(posedge clk);
        rd(`WPZ_OFS_STATUS);
        chk(d[6], 1'b1);
        $display("timeout done");
    endtask
    // Three words against a stalled host: the serializer holds one, the buffer two.
    task t_wave;
        logic [23:0] w[3];
        half(16'h8000);
        wr(`WPZ_OFS_MASK, 24'h010000);
        wr(`WPZ_OFS_WAVEFORM_MODE_REG, 24'h000004);
        stall <= 1;
        wpz_host_sink_inst.q.delete();
        strb(16'h8000);
        w[0] = 24'(vy);
        strb(16'h8000);
        w[1] = 24'(vy);
        strb(16'h8000);
        w[2] = 24'(vy);
        chk(irq_n, 1'b0);
        chk(v_mult[23:0], 24'h008000);
        chk(v_rms[23:0], {8'h00, w[2][15:0]});
        stall <= 0;
        repeat (20) @(posedge clk);
        chk(24'(wpz_host_sink_inst.q.size()), 24'd9);
        chk({wpz_host_sink_inst.q[0], wpz_host_sink_inst.q[1], wpz_host_sink_inst.q[2]}, w[0]);
        chk({wpz_host_sink_inst.q[3], wpz_host_sink_inst.q[4], wpz_host_sink_inst.q[5]}, w[1]);
        chk({wpz_host_sink_inst.q[6], wpz_host_sink_inst.q[7], wpz_host_sink_inst.q[8]}, w[2]);
        for (int r = 0; r < 4; r++) begin
            wr(`WPZ_OFS_WAVEFORM_MODE_REG, {17'h0, r[1:0], 5'h04});
            wpz_host_sink_inst.q.delete();
            repeat (8) strb(16'h8000);
            repeat (10) @(posedge clk);
            chk(24'(wpz_host_sink_inst.q.size()), 24'(3 * (8 >> r)));
        end
        $display("waveform done");
    endtask
    task test_done;
        $display("Checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1;
        t_over;
        t_zero;
        t_tout;
        t_wave;
        test_done;
    end
    // The tests need about 7000 cycles; a hang is cut well beyond that.
    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        test_done;
    end
endmodule
`default_nettype wire
